// ===== cblhbc_ctrl.sv
// Purpose: bus lock, hold hand-off, byte lanes, burst-last and failure signalling
// Assumes: inputs synchronous to clk; lock line pulled up outside the device
// Notes:   the address/data pins and strobes are decoded elsewhere from busState
//
// Contract
// - at start of read-modify-write, sample the lock line before the read.
// - if lock already asserted, stall the read-modify-write until it is released.
// - lock found free: drive it low during the read's address state.
// - release lock during the address state of the closing write.
// - drive lock low throughout interrupt-acknowledge transactions.
// - either party may assert lock; each honours the other's assertion.
// - lock low at reset end: float every output until next reset.
// - upper lane enable qualifies bits 15..8, lower enable bits 7..0.
// - byte-lane enables match transferred bytes in every data state.
// - burst-last low in final data state and its wait states.
// - failure shown as burst-last low with both lane enables high.
// - failure shown only between reset release and first bus transaction; code also shows it in every idle state after a failed checksum.
// - failure asserted during self-test, deasserted when self-test passes.
// - eight words must sum to zero, else failure reasserted for good.
// - on grant: float bus outputs first, then raise acknowledge, enter hold.
// - request removed: drop acknowledge, go to idle or address state.
// - acknowledge always driven, low during reset; code floats it in float mode.
// - ready not asserted in a data state: insert a wait state.
// - increment the word address bits for each burst beat.
`timescale 1ns/1ns

module cblhbc_ctrl
  import cblhbc_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // core access request
  input  wire logic         reqValid,
  input  cblhbc_req_t       req,
  output logic              reqReady,
  // core completion and read data
  output logic              accDone,
  output logic              rdValid,
  output logic [15:0]       rdData,
  // core self-test result
  input  wire logic         selfTestDone,
  input  wire logic         selfTestPass,
  // bus state for the address/data pin logic
  output cblhbc_state_t     busState,
  output logic              initFail,
  // bus inputs
  input  wire logic         readyN,
  input  wire logic [15:0]  busDataIn,
  input  wire logic         holdReq,
  // shared open-drain lock line
  input  wire logic         busLockIn,
  output logic              busLockOut,
  output logic              busLockOeN,
  // three-state bus control pins
  output cblhbc_pins_t      busPins,
  output logic              busPinsOeN,
  // hold acknowledge
  output logic              busGrantAck,
  output logic              busGrantAckOeN
);

  // ****************************************************************
  // registers
  // ****************************************************************
  cblhbc_state_t state_q, state_d;
  cblhbc_init_t  init_q;
  cblhbc_kind_t  kind_q, kind_d;
  logic [2:0]    beats_q, beats_d;
  logic [2:0]    wordAddr_q, wordAddr_d;
  logic [1:0]    lanes_q, lanes_d;
  logic          lockSeen_q, holdSeen_q;
  logic          lockDrive_q, lockDrive_d;
  logic          released_q;
  logic          floatMode_q;
  logic          floatNow;
  logic          fail_q;
  logic [3:0]    chkIdx_q;
  logic [31:0]   chkSum_q;
  logic [31:0]   chkSumNext;
  logic          internalGo, coreGo, startGo, beatDone, lastDone;
  cblhbc_req_t   startReq;

  // true while the engine sits in a data or wait state
  function automatic logic inData(input cblhbc_state_t s);
    inData = (s == ST_DATA) || (s == ST_WAIT);
  endfunction

  // true while the bus is handed to an external master
  function automatic logic inHold(input cblhbc_state_t s);
    inHold = (s == ST_HOLD_FLOAT) || (s == ST_HOLD);
  endfunction

  // ****************************************************************
  // input sampling
  // ****************************************************************
  // lock and hold taken into flops before the request and state decisions use them; float mode samples the raw lock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lockSeen_q <= 1'b1;
      holdSeen_q <= 1'b0;
    end else begin
      lockSeen_q <= busLockIn;
      holdSeen_q <= holdReq;
    end
  end

  // emulator float mode caught at the first edge after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      released_q  <= 1'b0;
      floatMode_q <= 1'b0;
    end else if (!released_q) begin
      released_q  <= 1'b1;
      floatMode_q <= ~busLockIn;
    end
  end

  // float also on the release edge itself, so no output is driven for one cycle
  assign floatNow = floatMode_q || (!released_q && !busLockIn);

  // ****************************************************************
  // request selection
  // ****************************************************************
  // checksum reads are two full-width eight-beat bursts from word zero
  assign internalGo = (init_q == INIT_CHECKSUM) && (state_q == ST_IDLE) && !holdSeen_q;

  // a read-modify-write read waits while someone else holds the lock
  always_comb begin
    // a pending hold must not block the write that frees our own lock
    reqReady = (init_q == INIT_RUN)
               && (((state_q == ST_IDLE) && (!holdSeen_q || lockDrive_q))
                   || ((state_q == ST_HOLD) && !holdSeen_q));
    if (req.kind == ACC_RMW_READ && !lockSeen_q) begin
      reqReady = 1'b0;
    end
  end

  assign coreGo  = reqValid && reqReady;
  assign startGo = internalGo || coreGo;

  always_comb begin
    startReq = req;
    if (internalGo) begin
      startReq.kind        = ACC_READ;
      startReq.wordAddr    = WORD_ADDR_RST;
      startReq.lastBeat    = CHK_BURST_LAST;
      startReq.byteLaneEnN = LANES_BOTH;
    end
  end

  assign beatDone = inData(state_q) && !readyN;
  assign lastDone = beatDone && (beats_q == BEATS_RST);

  // ****************************************************************
  // bus state sequencing
  // ****************************************************************
  // hold wins over a new access; never grant while we drive the lock
  always_comb begin
    state_d     = state_q;
    kind_d      = kind_q;
    beats_d     = beats_q;
    wordAddr_d  = wordAddr_q;
    lanes_d     = lanes_q;
    lockDrive_d = lockDrive_q;
    case (state_q)
      ST_IDLE: begin
        if (holdSeen_q && !lockDrive_q) begin
          state_d = ST_HOLD_FLOAT;
        end else if (startGo) begin
          state_d    = ST_ADDR;
          kind_d     = startReq.kind;
          beats_d    = startReq.lastBeat;
          wordAddr_d = startReq.wordAddr;
          lanes_d    = startReq.byteLaneEnN;
          if (startReq.kind == ACC_RMW_READ || startReq.kind == ACC_INT_ACK) begin
            lockDrive_d = 1'b1;
          end else if (startReq.kind == ACC_RMW_WRITE) begin
            lockDrive_d = 1'b0;
          end
        end
      end
      ST_ADDR: begin
        state_d = ST_DATA;
      end
      ST_DATA, ST_WAIT: begin
        if (readyN) begin
          state_d = ST_WAIT;
        end else if (beats_q == BEATS_RST) begin
          state_d = ST_IDLE;
          if (kind_q == ACC_INT_ACK) begin
            lockDrive_d = 1'b0;
          end
        end else begin
          state_d    = ST_DATA;
          beats_d    = beats_q - 3'h1;
          wordAddr_d = wordAddr_q + 3'h1;
        end
      end
      ST_HOLD_FLOAT: begin
        state_d = ST_HOLD;
      end
      ST_HOLD: begin
        // request gone: straight to address state if a core access waits
        if (!holdSeen_q) begin
          state_d = ST_IDLE;
          if (coreGoFromHold(reqValid, req, init_q, lockSeen_q)) begin
            state_d    = ST_ADDR;
            kind_d     = req.kind;
            beats_d    = req.lastBeat;
            wordAddr_d = req.wordAddr;
            lanes_d    = req.byteLaneEnN;
            if (req.kind == ACC_RMW_READ || req.kind == ACC_INT_ACK) begin
              lockDrive_d = 1'b1;
            end else if (req.kind == ACC_RMW_WRITE) begin
              lockDrive_d = 1'b0;
            end
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // a held core request may start on the release edge of hold
  function automatic logic coreGoFromHold(input logic v, input cblhbc_req_t r,
                                          input cblhbc_init_t ph, input logic lockFree);
    coreGoFromHold = v && (ph == INIT_RUN) && (r.kind != ACC_RMW_READ || lockFree);
  endfunction

  // engine registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      kind_q      <= ACC_READ;
      beats_q     <= BEATS_RST;
      wordAddr_q  <= WORD_ADDR_RST;
      lanes_q     <= LANES_OFF;
      lockDrive_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      kind_q      <= kind_d;
      beats_q     <= beats_d;
      wordAddr_q  <= wordAddr_d;
      lanes_q     <= lanes_d;
      lockDrive_q <= lockDrive_d;
    end
  end

  // ****************************************************************
  // initialisation and checksum
  // ****************************************************************
  assign chkSumNext = chkSum_q + (chkIdx_q[0] ? {busDataIn, 16'h0000} : {16'h0000, busDataIn});

  // failure stays up through self-test; a bad sum latches it for good
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_q   <= INIT_SELF_TEST;
      fail_q   <= 1'b1;
      chkIdx_q <= 4'h0;
      chkSum_q <= CHK_SUM_RST;
    end else begin
      case (init_q)
        INIT_SELF_TEST: begin
          if (selfTestDone) begin
            init_q <= selfTestPass ? INIT_CHECKSUM : INIT_DEAD;
            fail_q <= ~selfTestPass;
          end
        end
        INIT_CHECKSUM: begin
          if (beatDone) begin
            chkIdx_q <= chkIdx_q + 4'h1;
            chkSum_q <= chkSumNext;
            if (chkIdx_q == CHK_LAST_HALF) begin
              init_q <= (chkSumNext == CHK_SUM_RST) ? INIT_RUN : INIT_DEAD;
              fail_q <= (chkSumNext != CHK_SUM_RST);
            end
          end
        end
        INIT_RUN: begin
          fail_q <= 1'b0;
        end
        INIT_DEAD: begin
          fail_q <= 1'b1;
        end
        default: begin
          init_q <= INIT_DEAD;
        end
      endcase
    end
  end

  // ****************************************************************
  // core completion
  // ****************************************************************
  // checksum traffic is kept away from the core's completion signals
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accDone <= 1'b0;
      rdValid <= 1'b0;
      rdData  <= RD_DATA_RST;
    end else begin
      accDone <= lastDone && (init_q == INIT_RUN);
      rdValid <= beatDone && (init_q == INIT_RUN);
      if (beatDone) begin
        rdData <= busDataIn;
      end
    end
  end

  // ****************************************************************
  // pin outputs
  // ****************************************************************
  // the lock pin only ever pulls low; release is by the enable alone
  assign busLockOut = 1'b0;

  // outputs registered from next-state values so they line up with the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busState             <= ST_IDLE;
      busLockOeN           <= 1'b1;
      busPins.byteLaneEnN  <= LANES_OFF;
      busPins.burstLastN   <= 1'b1;
      busPins.wordAddrBits <= WORD_ADDR_RST;
      busPinsOeN           <= 1'b1;
      busGrantAck          <= 1'b0;
      busGrantAckOeN       <= 1'b0;
      initFail             <= 1'b1;
    end else begin
      busState             <= state_d;
      busLockOeN           <= floatNow | ~lockDrive_d;
      busPins.byteLaneEnN  <= inData(state_d) ? lanes_d : LANES_OFF;
      busPins.burstLastN   <= ~((inData(state_d) && beats_d == BEATS_RST)
                                || (fail_q && state_d == ST_IDLE));
      busPins.wordAddrBits <= wordAddr_d;
      busPinsOeN           <= floatNow | inHold(state_d);
      busGrantAck          <= (state_d == ST_HOLD);
      busGrantAckOeN       <= floatNow;
      initFail             <= fail_q;
    end
  end

endmodule

// ===== cblhbc_ctrl_sva.sv
// Purpose: concurrent checks on the ports of the lock, hold and burst block
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   bound to every instance of cblhbc_ctrl
`timescale 1ns/1ns

module cblhbc_ctrl_sva
  import cblhbc_pkg::*;
(
  // clock and reset
  input wire logic     clk,
  input wire logic     rst,
  // core side
  input wire logic     reqValid,
  input cblhbc_req_t   req,
  input wire logic     reqReady,
  input cblhbc_state_t busState,
  input wire logic     initFail,
  // bus side
  input wire logic     readyN,
  input wire logic     holdReq,
  input wire logic     busLockIn,
  input wire logic     busLockOeN,
  input cblhbc_pins_t  busPins,
  input wire logic     busPinsOeN,
  input wire logic     busGrantAck,
  input wire logic     busGrantAckOeN
);
  // ****************************************
  // helpers
  // ****************************************
  logic firstQ;
  logic floatQ;
  logic rstSeenQ;

  // marks the first edge after release, where the lock wire is sampled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      firstQ <= 1'b1;
    end else begin
      firstQ <= 1'b0;
    end
  end

  // float mode seen; no reset on rstSeenQ so time zero stays vacuous
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      floatQ <= 1'b0;
    end else if (firstQ && !busLockIn) begin
      floatQ <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    rstSeenQ <= rst;
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_rmw_lock_drive: assert property (reqValid && reqReady
    && req.kind == ACC_RMW_READ
    |=> !busLockOeN && busState == ST_ADDR) else $error("lock not driven for locked read");
  a_rmw_lock_free: assert property (reqValid && reqReady && req.kind == ACC_RMW_WRITE
    |=> busLockOeN) else $error("lock not released for locked write");
  a_rmw_stall: assert property (reqValid && req.kind == ACC_RMW_READ
    && !$past(busLockIn)
    |-> !reqReady) else $error("locked read taken under foreign lock");
  a_float_all_out: assert property (floatQ
    |-> busPinsOeN && busLockOeN && busGrantAckOeN) else $error("output driven in float mode");
  a_ack_in_reset: assert property (disable iff (1'b0) rst && rstSeenQ
    |-> !busGrantAck && !busGrantAckOeN) else $error("ack not driven low in reset");
  a_hold_float_first: assert property ($rose(busGrantAck)
    |-> busPinsOeN && $past(busPinsOeN)) else $error("ack raised before pins floated");
  a_hold_lock_excl: assert property (!busLockOeN |-> !busGrantAck)
    else $error("hold granted while lock driven");
  // judged from the edge the request drops only: a waiting access may follow at once
  a_hold_release: assert property (busGrantAck && $fell(holdReq)
    |=> ##1 !busGrantAck && busState inside {ST_IDLE, ST_ADDR}) else $error("ack not dropped");
  a_wait_insert: assert property (busState == ST_DATA && readyN
    |=> busState == ST_WAIT && $stable(busPins)) else $error("no wait state on not ready");
  a_addr_step: assert property ((busState inside {ST_DATA, ST_WAIT}) && !readyN
    && busPins.burstLastN |=> busPins.wordAddrBits == $past(busPins.wordAddrBits) + 3'h1)
    else $error("word address not stepped");
  a_fail_code: assert property (!firstQ && initFail && busState == ST_IDLE
    |-> !busPins.burstLastN && busPins.byteLaneEnN == LANES_OFF) else $error("bad fail code");
  a_burst_last_n_cause: assert property (!busPins.burstLastN
    |-> busState inside {ST_DATA, ST_WAIT} || initFail) else $error("stray burst last");
endmodule

bind cblhbc_ctrl cblhbc_ctrl_sva u_sva (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
  .reqReady(reqReady), .busState(busState), .initFail(initFail), .readyN(readyN),
  .holdReq(holdReq), .busLockIn(busLockIn), .busLockOeN(busLockOeN), .busPins(busPins),
  .busPinsOeN(busPinsOeN), .busGrantAck(busGrantAck), .busGrantAckOeN(busGrantAckOeN));

// ===== cblhbc_ctrl_test.sv
// Purpose: self-checking bench of the lock, hold and burst block
// Assumes: far-end model answers reads with fillVal
// Notes:   each scenario is one task; run ends in test_done
`timescale 1ns/1ns

module cblhbc_ctrl_test
  import cblhbc_pkg::*;
;
  localparam int CYCLE_LIMIT = 5000;
  logic clk, rst, reqValid, selfTestDone, selfTestPass, holdReq, waitEn, otherLock;
  logic reqReady, accDone, rdValid, initFail, readyN, busLockIn, busLockOut, busLockOeN;
  logic busPinsOeN, busGrantAck, busGrantAckOeN;
  logic [15:0] rdData, busDataIn, fillVal;
  cblhbc_req_t req;
  cblhbc_state_t busState;
  cblhbc_pins_t busPins;
  int mismatches, checks, cycles;

  cblhbc_ctrl u_dut (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .accDone(accDone), .rdValid(rdValid), .rdData(rdData), .selfTestDone(selfTestDone),
    .selfTestPass(selfTestPass), .busState(busState), .initFail(initFail), .readyN(readyN),
    .busDataIn(busDataIn), .holdReq(holdReq), .busLockIn(busLockIn), .busLockOut(busLockOut),
    .busLockOeN(busLockOeN), .busPins(busPins), .busPinsOeN(busPinsOeN),
    .busGrantAck(busGrantAck), .busGrantAckOeN(busGrantAckOeN));
  cblhbc_far_end u_far (.clk(clk), .busState(busState), .busLockOut(busLockOut),
    .busLockOeN(busLockOeN), .waitEn(waitEn), .otherLock(otherLock), .fillVal(fillVal),
    .readyN(readyN), .busDataIn(busDataIn), .busLockIn(busLockIn));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] expV, input logic [15:0] gotV);
    checks++;
    if (gotV !== expV) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, expV, gotV);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // lock wire may be held low across release to ask for float mode
  task automatic do_reset(input logic lockLow);
    @(posedge clk);
    otherLock <= lockLow;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    otherLock <= 1'b0;
  endtask

  task automatic init_run(input logic stPass, input logic [15:0] fillV, input int expBeats,
                          input logic expFail);
    int beats;
    beats = 0;
    fillVal <= fillV;
    @(negedge clk);
    check("fail flag", 16'h1, 16'(initFail));
    check("fail pins", 16'h6, 16'({busPins.byteLaneEnN, busPins.burstLastN}));
    @(posedge clk);
    selfTestDone <= 1'b1;
    selfTestPass <= stPass;
    @(posedge clk);
    selfTestDone <= 1'b0;
    repeat (80) begin
      @(negedge clk);
      // checksum beats never reach rdValid, so they are counted on the bus
      beats += int'(busState == ST_DATA && readyN === 1'b0);
    end
    check("checksum beats", 16'(expBeats), 16'(beats));
    check("fail after init", 16'(expFail), 16'(initFail));
  endtask

  // one core access, every bus cycle judged while it runs
  task automatic access(input cblhbc_kind_t kind, input logic [2:0] addr,
                        input logic [2:0] last, input logic [1:0] lanes);
    int beat;
    int n;
    logic lockExp;
    beat = 0;
    n = 0;
    lockExp = !(kind == ACC_RMW_READ || kind == ACC_INT_ACK);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{kind, addr, last, lanes};
    do begin
      @(negedge clk);
      n++;
    end while (reqReady !== 1'b1 && n < 50);
    @(posedge clk);
    reqValid <= 1'b0;
    // body also runs in the done cycle, so the last beat's data is judged
    do begin
      @(negedge clk);
      n++;
      if (busState != ST_IDLE) begin
        check("lock drive", 16'(lockExp), 16'(busLockOeN));
      end
      if (busState inside {ST_DATA, ST_WAIT}) begin
        check("lanes", 16'(lanes), 16'(busPins.byteLaneEnN));
        check("word addr", 16'(3'(addr + 3'(beat))), 16'(busPins.wordAddrBits));
        check("burst last", 16'(beat != int'(last)), 16'(busPins.burstLastN));
        beat += int'(readyN === 1'b0);
      end
      if (rdValid === 1'b1) begin
        check("read data", fillVal, rdData);
      end
    end while (accDone !== 1'b1 && n < 120);
    check("beats", 16'(int'(last) + 1), 16'(beat));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_lock_pair();
    @(posedge clk);
    otherLock <= 1'b1;
    // the lock reaches the design one edge late, so ask only after that
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{ACC_RMW_READ, 3'h1, 3'h0, LANES_BOTH};
    repeat (4) begin
      @(negedge clk);
      check("stalled by lock", 16'h0, 16'(reqReady));
    end
    @(posedge clk);
    otherLock <= 1'b0;
    access(ACC_RMW_READ, 3'h1, 3'h0, LANES_BOTH);
    access(ACC_RMW_WRITE, 3'h1, 3'h0, LANES_BOTH);
  endtask

  task automatic t_hold();
    int n;
    n = 0;
    @(posedge clk);
    holdReq <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (busGrantAck !== 1'b1 && n < 10);
    check("grant pins", 16'h3, 16'({busGrantAck, busPinsOeN}));
    repeat (3) @(posedge clk);
    holdReq <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (busGrantAck !== 1'b0 && n < 30);
    check("release", 16'h0, 16'({busGrantAck, busPinsOeN, busGrantAckOeN}));
  endtask

  task automatic t_float();
    do_reset(1'b1);
    repeat (3) @(negedge clk);
    check("float mode", 16'h7, 16'({busPinsOeN, busLockOeN, busGrantAckOeN}));
  endtask

  // ****************************************
  // run
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles > CYCLE_LIMIT) begin
        mismatches++;
        $display("[ERR] cycle limit expected %0d seen %0d", CYCLE_LIMIT, cycles);
        test_done();
      end
    end
  end

  initial begin
    {rst, reqValid, selfTestDone, selfTestPass, holdReq, waitEn, otherLock} = 7'h41;
    req = '0;
    fillVal = 16'h0000;
    mismatches = 0;
    checks = 0;
    do_reset(1'b0);
    init_run(1'b0, 16'h0000, 0, 1'b1);
    do_reset(1'b0);
    init_run(1'b1, 16'h0001, 16, 1'b1);
    do_reset(1'b0);
    init_run(1'b1, 16'h0000, 16, 1'b0);
    fillVal <= 16'hC35A;
    waitEn <= 1'b1;
    access(ACC_READ, 3'h6, 3'h3, 2'h1);
    waitEn <= 1'b0;
    access(ACC_WRITE, 3'h0, 3'h0, 2'h2);
    access(ACC_READ, 3'h2, 3'h7, LANES_BOTH);
    access(ACC_INT_ACK, 3'h0, 3'h0, LANES_BOTH);
    t_lock_pair();
    t_hold();
    t_float();
    test_done();
  end
endmodule

// ===== cblhbc_far_end.sv
// Purpose: memory and bus agent model on the far side of the block
// Assumes: lock wire has a pull-up; one wait state per beat when slowed
// Notes:   released data lines show the inverse of the last word
`timescale 1ns/1ns

module cblhbc_far_end
  import cblhbc_pkg::*;
(
  // clock and bus state
  input  wire logic         clk,
  input  cblhbc_state_t     busState,
  input  wire logic         busLockOut,
  input  wire logic         busLockOeN,
  // scenario controls
  input  wire logic         waitEn,
  input  wire logic         otherLock,
  input  wire logic [15:0]  fillVal,
  // answers to the block
  output logic              readyN,
  output logic [15:0]       busDataIn,
  output logic              busLockIn
);
  logic [15:0] lastQ = 16'h0000;

  // slow memory holds off every data state once
  assign readyN = waitEn && (busState == ST_DATA);
  // outside data states the stale word must not look valid
  assign busDataIn = (busState inside {ST_DATA, ST_WAIT}) ? fillVal : ~lastQ;
  always_ff @(posedge clk) begin
    lastQ <= busDataIn;
  end
  // wired lock with pull-up; this agent never starts its own locked pair
  assign busLockIn = !(otherLock || (!busLockOeN && !busLockOut));
endmodule

// ===== cblhbc_pkg.sv
// Purpose: shared types and constants of the bus lock, hold and burst control block
// Assumes: one 10 MHz bus-state clock, all pin inputs synchronous to it
// Notes:   pin groups travel as packed structs; enables of pins are active low

// ****************************************************************
// package
// ****************************************************************
package cblhbc_pkg;

  // bus states of the engine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_WAIT,
    ST_HOLD_FLOAT,
    ST_HOLD
  } cblhbc_state_t;

  // kinds of access that the core may request
  typedef enum logic [2:0] {
    ACC_READ,
    ACC_WRITE,
    ACC_RMW_READ,
    ACC_RMW_WRITE,
    ACC_INT_ACK
  } cblhbc_kind_t;

  // initialisation phases
  typedef enum logic [1:0] {
    INIT_SELF_TEST,
    INIT_CHECKSUM,
    INIT_RUN,
    INIT_DEAD
  } cblhbc_init_t;

  // one access request from the core
  typedef struct packed {
    cblhbc_kind_t kind;
    logic [2:0]   wordAddr;  // first word address
    logic [2:0]   lastBeat;  // beats in burst minus one
    logic [1:0]   byteLaneEnN;
  } cblhbc_req_t;

  // three-state bus pins driven by this block
  typedef struct packed {
    logic [1:0] byteLaneEnN;
    logic       burstLastN;
    logic [2:0] wordAddrBits;
  } cblhbc_pins_t;

  // field widths and idle values
  localparam int          WORD_ADDR_W    = 3;
  localparam logic [1:0]  LANES_OFF      = 2'h3;
  localparam logic [1:0]  LANES_BOTH     = 2'h0;
  localparam logic [2:0]  WORD_ADDR_RST  = 3'h0;
  localparam logic [2:0]  BEATS_RST      = 3'h0;
  // checksum covers eight 32-bit words, i.e. sixteen bus halfwords
  localparam int          CHK_WORDS      = 8;
  localparam logic [3:0]  CHK_LAST_HALF  = 4'(2 * CHK_WORDS - 1);
  localparam logic [2:0]  CHK_BURST_LAST = 3'h7;
  localparam logic [31:0] CHK_SUM_RST    = 32'h0000_0000;
  localparam logic [15:0] RD_DATA_RST    = 16'h0000;

endpackage
